// File: pkg/wit_pkg.sv
package wit_pkg;

    // ==========================================================
    // Register bus geometry
    localparam int WIT_DATA_W = 8;
    localparam int WIT_ADDR_W = 3;

    // ==========================================================
    // Register offsets
    localparam logic [2:0] WIT_ADDR_CSR_ONE = 3'h0;
    localparam logic [2:0] WIT_ADDR_CSR_TWO = 3'h1;
    localparam logic [2:0] WIT_ADDR_COUNTER = 3'h2;
    localparam logic [2:0] WIT_ADDR_CLK_MODE = 3'h3;
    localparam logic [2:0] WIT_ADDR_CLK_STOP = 3'h4;
    localparam logic [2:0] WIT_ADDR_IRQ_STATUS = 3'h5;
    localparam logic [2:0] WIT_ADDR_IRQ_MASK = 3'h6;

    // ==========================================================
    // Field positions, control/status one
    localparam int WIT_CS1_WE_BIT = 3;
    localparam int WIT_CS1_GUARD_BIT = 2;
    localparam int WIT_CS1_RUN_BIT = 1;
    localparam logic [7:0] WIT_CS1_READ_ONES = 8'hF5;

    // Field positions, control/status two
    localparam int WIT_CS2_OVF_BIT = 7;
    localparam int WIT_CS2_MODE_GUARD_BIT = 6;
    localparam int WIT_CS2_MODE_BIT = 5;
    localparam int WIT_CS2_IE_GUARD_BIT = 4;
    localparam int WIT_CS2_IE_BIT = 3;
    localparam logic [7:0] WIT_CS2_READ_ONES = 8'h57;

    // Clock mode, clock stop, interrupt status fields
    localparam logic [7:0] WIT_CKM_READ_ONES = 8'hF0;
    localparam int WIT_STOP_BIT = 0;
    localparam int WIT_EV_OVERFLOW = 0;
    localparam int WIT_EV_STARTED = 1;
    localparam int WIT_EV_W = 2;

    // ==========================================================
    // Reset values and counter maximum
    localparam logic [7:0] WIT_COUNTER_RST = 8'h00;
    localparam logic [7:0] WIT_COUNTER_MAX = 8'hFF;
    localparam logic [3:0] WIT_CKS_RST = 4'hF;

    // ==========================================================
    // Timing counts
    localparam int WIT_RESET_PULSE_OSC = 512;
    localparam int WIT_PULSE_CNT_W = $clog2(WIT_RESET_PULSE_OSC);
    localparam int WIT_OSC_DIV = 2048;
    localparam int WIT_OSC_DIV_W = $clog2(WIT_OSC_DIV);
    localparam int WIT_SYS_DIV_BASE_LOG2 = 6;
    localparam int WIT_SYS_DIV_W = WIT_SYS_DIV_BASE_LOG2 + 7;

    // ==========================================================
    // Timer phase, Gray coded along stop, run, reset
    typedef enum logic [1:0] {
        WIT_PH_STOP = 2'b00,
        WIT_PH_RUN = 2'b01,
        WIT_PH_RESET = 2'b11
    } wit_phase_t;

endpackage

// File: hdl/wit_prescaler.sv
module wit_prescaler
    import wit_pkg::*;
#(
    parameter int SYS_DIV_W = WIT_SYS_DIV_W,
    parameter int OSC_DIV_W = WIT_OSC_DIV_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic hold,
    input wire logic osc_tick,
    input wire logic [3:0] clock_select,
    // Count pulse toward the counter
    output logic count_pulse
);

    typedef struct packed {
        logic [SYS_DIV_W-1:0] sys_div;
        logic [OSC_DIV_W-1:0] osc_div;
        logic pulse;
    } wit_pre_state_t;

    wit_pre_state_t st;
    wit_pre_state_t next_st;

    // ==========================================================
    // Tap of the system divider for one select code
    function automatic logic sys_tap(input logic [SYS_DIV_W-1:0] div, input logic [2:0] code);
        logic [SYS_DIV_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < SYS_DIV_W; i++) begin
            if (i < WIT_SYS_DIV_BASE_LOG2 + int'(code)) begin
                mask[i] = 1'b1;
            end
        end
        return (div & mask) == mask;
    endfunction

    // ==========================================================
    // Dividers cleared while held, so a fresh start gets a full period
    always_comb begin
        next_st = st;
        if (hold) begin
            next_st = '0;
        end else begin
            next_st.sys_div = st.sys_div + 1'b1;
            if (osc_tick) begin
                next_st.osc_div = st.osc_div + 1'b1;
            end
            // Top select bit picks system clock, else oscillator /2048
            if (clock_select[3]) begin
                next_st.pulse = sys_tap(st.sys_div, clock_select[2:0]);
            end else begin
                next_st.pulse = osc_tick && (st.osc_div == '1);
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count_pulse = st.pulse;

endmodule

// File: hdl/wit_timer.sv
// Functional notes
// - One 8-bit up-counter, one step per selected input clock pulse.
// - Run starts on run=1, guard=0 while write enable already set.
// - Watchdog mode: pulse at 0xFF wraps counter and raises reset request.
// - Reset request lasts exactly 512 oscillator cycles.
// - Counter is writable; counting continues from the written value.
// - Interval mode: every overflow requests an interrupt, never a reset.
// - Overflow flag sets in the same cycle as reset or interrupt.
// - Interval request is high while overflow flag and enable are both 1.
// - Module stop acts only while run is 0; standby starts at stop.
// - Mode bit changes only when its guard is written 0; guard reads 1.
// - Mode 0 is watchdog, 1 is interval; reset value 0.
// - Clock select 1xxx picks system clock /64../8192, 0xxx oscillator /2048.
// - Flag clears on write 0 after a read of 1, or by watchdog reset.
module wit_timer
    import wit_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // On-chip oscillator, asynchronous to clk
    input wire logic osc_clk,
    // Register port
    input wire logic [WIT_ADDR_W-1:0] addr,
    input wire logic [WIT_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [WIT_DATA_W-1:0] rdata,
    // Requests toward the system
    output logic wdt_reset_req,
    output logic interval_irq,
    output logic irq,
    output logic module_standby
);

    // ==========================================================
    // State
    typedef struct packed {
        logic osc_sync1;
        logic osc_sync2;
        logic osc_prev;
        wit_phase_t phase;
        logic [7:0] counter;
        logic write_enable;
        logic mode;
        logic irq_en;
        logic ovf;
        logic ovf_armed;
        logic [3:0] cks;
        logic mod_stop;
        logic [WIT_PULSE_CNT_W-1:0] pulse_cnt;
        logic [WIT_EV_W-1:0] status;
        logic [WIT_EV_W-1:0] mask;
        logic [WIT_DATA_W-1:0] rdata;
        logic reset_req;
        logic interval_irq;
        logic irq;
        logic standby;
    } wit_state_t;

    wit_state_t st;
    wit_state_t next_st;
    logic count_pulse;
    logic osc_tick;
    logic running;
    logic overflow;
    logic accept_wr;

    // ==========================================================
    // Register read-back
    function automatic logic [7:0] read_value(input wit_state_t s, input logic [2:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == WIT_ADDR_CSR_ONE) begin
            v = WIT_CS1_READ_ONES;
            v[WIT_CS1_WE_BIT] = s.write_enable;
            v[WIT_CS1_RUN_BIT] = (s.phase == WIT_PH_RUN);
        end else if (a == WIT_ADDR_CSR_TWO) begin
            // Guard bits always read as one
            v = WIT_CS2_READ_ONES;
            v[WIT_CS2_OVF_BIT] = s.ovf;
            v[WIT_CS2_MODE_BIT] = s.mode;
            v[WIT_CS2_IE_BIT] = s.irq_en;
        end else if (a == WIT_ADDR_COUNTER) begin
            v = s.counter;
        end else if (a == WIT_ADDR_CLK_MODE) begin
            v = WIT_CKM_READ_ONES | {4'h0, s.cks};
        end else if (a == WIT_ADDR_CLK_STOP) begin
            v[WIT_STOP_BIT] = s.mod_stop;
        end else if (a == WIT_ADDR_IRQ_STATUS) begin
            v[WIT_EV_W-1:0] = s.status;
        end else if (a == WIT_ADDR_IRQ_MASK) begin
            v[WIT_EV_W-1:0] = s.mask;
        end
        return v;
    endfunction

    // ==========================================================
    // Prescaler; held while not running, which also covers standby
    wit_prescaler u_prescaler (
        .clk(clk),
        .reset_n(reset_n),
        .hold(!running),
        .osc_tick(osc_tick),
        .clock_select(st.cks),
        .count_pulse(count_pulse)
    );

    // Derived terms; the first sync stage feeds only the second
    assign osc_tick = st.osc_sync2 && !st.osc_prev;
    assign running = (st.phase == WIT_PH_RUN);
    assign overflow = running && count_pulse && (st.counter == WIT_COUNTER_MAX);
    // Writes during the reset pulse are dropped: the chip is in reset
    assign accept_wr = wr && (st.phase != WIT_PH_RESET);

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.osc_sync1 = osc_clk;
        next_st.osc_sync2 = st.osc_sync1;
        next_st.osc_prev = st.osc_sync2;

        // Counting
        if (running && count_pulse) begin
            next_st.counter = st.counter + 8'h01;
        end

        // Register writes
        if (accept_wr) begin
            if (addr == WIT_ADDR_CSR_ONE) begin
                next_st.write_enable = wdata[WIT_CS1_WE_BIT];
                // Guard 0 plus an enable set by an earlier write
                if (st.write_enable && !wdata[WIT_CS1_GUARD_BIT]) begin
                    if (wdata[WIT_CS1_RUN_BIT]) begin
                        next_st.phase = WIT_PH_RUN;
                        if (!running) begin
                            next_st.status[WIT_EV_STARTED] = 1'b1;
                        end
                    end else begin
                        next_st.phase = WIT_PH_STOP;
                    end
                end
            end else if (addr == WIT_ADDR_CSR_TWO) begin
                if (!wdata[WIT_CS2_MODE_GUARD_BIT]) begin
                    next_st.mode = wdata[WIT_CS2_MODE_BIT];
                end
                if (!wdata[WIT_CS2_IE_GUARD_BIT]) begin
                    next_st.irq_en = wdata[WIT_CS2_IE_BIT];
                end
                // Zero clears only after a read that saw the flag set
                if (!wdata[WIT_CS2_OVF_BIT] && st.ovf_armed) begin
                    next_st.ovf = 1'b0;
                end
                next_st.ovf_armed = 1'b0;
            end else if (addr == WIT_ADDR_COUNTER) begin
                next_st.counter = wdata;
            end else if (addr == WIT_ADDR_CLK_MODE) begin
                next_st.cks = wdata[3:0];
            end else if (addr == WIT_ADDR_CLK_STOP) begin
                next_st.mod_stop = wdata[WIT_STOP_BIT];
            end else if (addr == WIT_ADDR_IRQ_STATUS) begin
                next_st.status = next_st.status & ~wdata[WIT_EV_W-1:0];
            end else if (addr == WIT_ADDR_IRQ_MASK) begin
                next_st.mask = wdata[WIT_EV_W-1:0];
            end
        end

        // Reads: data stands for one cycle only
        next_st.rdata = 8'h00;
        if (rd) begin
            next_st.rdata = read_value(st, addr);
            if (addr == WIT_ADDR_CSR_TWO && st.ovf) begin
                next_st.ovf_armed = 1'b1;
            end
        end

        // Overflow comes after the writes so a set beats a clear
        if (overflow) begin
            next_st.ovf = 1'b1;
            next_st.status[WIT_EV_OVERFLOW] = 1'b1;
            if (!st.mode) begin
                // Watchdog: enter reset pulse, control back to initial
                next_st.phase = WIT_PH_RESET;
                next_st.pulse_cnt = '0;
                next_st.counter = WIT_COUNTER_RST;
                next_st.write_enable = 1'b0;
                next_st.mode = 1'b0;
                next_st.irq_en = 1'b0;
                next_st.cks = WIT_CKS_RST;
                next_st.mod_stop = 1'b0;
                next_st.ovf_armed = 1'b0;
            end
        end

        // Reset pulse timed on oscillator edges
        if (st.phase == WIT_PH_RESET && osc_tick) begin
            next_st.pulse_cnt = st.pulse_cnt + 1'b1;
            if (st.pulse_cnt == WIT_PULSE_CNT_W'(WIT_RESET_PULSE_OSC - 1)) begin
                next_st.phase = WIT_PH_STOP;
                next_st.ovf = 1'b0;
            end
        end

        // Registered outputs
        next_st.reset_req = (next_st.phase == WIT_PH_RESET);
        next_st.interval_irq = next_st.ovf && next_st.irq_en;
        next_st.irq = |(next_st.status & next_st.mask);
        // Stop request takes hold only once run is cleared
        next_st.standby = next_st.mod_stop && (next_st.phase != WIT_PH_RUN);
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
            st.cks <= WIT_CKS_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign rdata = st.rdata;
    assign wdt_reset_req = st.reset_req;
    assign interval_irq = st.interval_irq;
    assign irq = st.irq;
    assign module_standby = st.standby;

    // ==========================================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_run_start_ok: assert property (
        (accept_wr && addr == WIT_ADDR_CSR_ONE && st.write_enable
         && wdata[WIT_CS1_RUN_BIT] && !wdata[WIT_CS1_GUARD_BIT] && !overflow)
        |=> (st.phase == WIT_PH_RUN))
        else $error("run did not start on a guarded write");

    a_run_start_blocked: assert property (
        (st.phase == WIT_PH_STOP && !(accept_wr && addr == WIT_ADDR_CSR_ONE
         && st.write_enable && !wdata[WIT_CS1_GUARD_BIT]))
        |=> (st.phase != WIT_PH_RUN))
        else $error("run started without enable and guard");

    a_count_step: assert property (
        (running && count_pulse && !overflow
         && !(accept_wr && addr == WIT_ADDR_COUNTER))
        |=> (st.counter == 8'($past(st.counter) + 8'h01)))
        else $error("counter did not step by one");

    a_counter_load: assert property (
        (accept_wr && addr == WIT_ADDR_COUNTER && !overflow)
        |=> (st.counter == $past(wdata)))
        else $error("written count not kept");

    // After a load the count holds or steps once; a cycle that overflows at 0xFF is left out
    a_counter_resume: assert property (
        (running && $past(accept_wr && addr == WIT_ADDR_COUNTER) && !overflow
         && !(accept_wr && addr == WIT_ADDR_COUNTER))
        |=> (st.counter == $past(st.counter) || st.counter == 8'($past(st.counter) + 8'h01)))
        else $error("count did not continue from written value");

    a_wdt_overflow: assert property (
        (overflow && !st.mode)
        |=> (st.ovf && st.counter == WIT_COUNTER_RST && !st.irq_en && !st.mode)
            ##1 wdt_reset_req)
        else $error("watchdog overflow without reset");

    a_reset_len_end: assert property (
        (st.phase == WIT_PH_RESET && osc_tick
         && st.pulse_cnt == WIT_PULSE_CNT_W'(WIT_RESET_PULSE_OSC - 1))
        |=> ##1 (!wdt_reset_req && !st.ovf))
        else $error("reset pulse did not end after 512 oscillator cycles");

    a_reset_len_hold: assert property (
        (wdt_reset_req && !(osc_tick && st.pulse_cnt == '1)) |=> wdt_reset_req)
        else $error("reset pulse ended early");

    // A stop written in the overflow cycle is legal, so only the reset phase is barred
    a_interval_irq: assert property (
        (overflow && st.mode) |=> (st.ovf && st.phase != WIT_PH_RESET) ##1 !wdt_reset_req)
        else $error("interval overflow caused reset");

    // Request and its terms are registered together, so they agree every cycle
    a_irq_level: assert property (
        interval_irq == (st.ovf && st.irq_en))
        else $error("interval request does not follow flag and enable");

    a_mode_guard: assert property (
        (accept_wr && addr == WIT_ADDR_CSR_TWO && wdata[WIT_CS2_MODE_GUARD_BIT] && !overflow)
        |=> $stable(st.mode))
        else $error("mode changed with guard set");

    a_ovf_unarmed: assert property (
        (st.ovf && !st.ovf_armed && st.phase != WIT_PH_RESET) |=> st.ovf)
        else $error("overflow flag cleared without prior read");

    a_standby_run: assert property (
        module_standby == (st.mod_stop && !running))
        else $error("standby does not follow stop request and run bit");

    // ==========================================================
    // Checks on flag, guard, counter and reset-pulse write paths
    a_interval_wrap: assert property (
        (overflow && st.mode && !(accept_wr && addr == WIT_ADDR_COUNTER))
        |=> (st.counter == WIT_COUNTER_RST && !wdt_reset_req))
        else $error("interval overflow did not wrap the counter");

    // A write that touches the enable would mask the pairing, so it is left out
    a_ovf_with_irq: assert property (
        (overflow && st.mode && st.irq_en && !(accept_wr && addr == WIT_ADDR_CSR_TWO))
        |=> (st.ovf && interval_irq))
        else $error("flag and interrupt not raised together");

    a_ovf_status: assert property (
        overflow |=> (st.ovf && st.status[WIT_EV_OVERFLOW]))
        else $error("overflow event not recorded");

    a_guard_read: assert property (
        (rd && addr == WIT_ADDR_CSR_TWO)
        |=> (rdata[WIT_CS2_MODE_GUARD_BIT] && rdata[WIT_CS2_IE_GUARD_BIT]))
        else $error("guard bits did not read as one");

    a_ie_guard: assert property (
        (accept_wr && addr == WIT_ADDR_CSR_TWO && wdata[WIT_CS2_IE_GUARD_BIT] && !overflow)
        |=> $stable(st.irq_en))
        else $error("enable changed with guard set");

    // Prescaler is held while stopped, so only a load may move the count
    a_count_idle: assert property (
        (!running && !(accept_wr && addr == WIT_ADDR_COUNTER)) |=> $stable(st.counter))
        else $error("counter moved while stopped");

    a_reset_no_write: assert property (
        (wr && st.phase == WIT_PH_RESET) |=> (!st.write_enable && st.cks == WIT_CKS_RST))
        else $error("control written during reset pulse");

endmodule

// File: bench/wit_timer_test.sv
module wit_timer_test
    import wit_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Stimulus and observation
    logic clk;
    logic reset_n;
    logic osc_clk;
    logic [WIT_ADDR_W-1:0] addr;
    logic [WIT_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [WIT_DATA_W-1:0] rdata;
    logic wdt_reset_req;
    logic interval_irq;
    logic irq;
    logic module_standby;
    int miscompares;
    int checked;
    int width;
    logic [7:0] pats [3];
    logic [7:0] left [3];

    wit_timer uut (
        .clk(clk),
        .reset_n(reset_n),
        .osc_clk(osc_clk),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .wdt_reset_req(wdt_reset_req),
        .interval_irq(interval_irq),
        .irq(irq),
        .module_standby(module_standby)
    );

    // ==========================================================
    // Clocks: oscillator period 100 ns, so 512 ticks span 2560 cycles
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Oscillator offset so its edges never share a time step with clk
    initial begin
        osc_clk = 1'b0;
        #3;
        forever #50 osc_clk = ~osc_clk;
    end

    // ==========================================================
    // Checking and bus tasks
    `define CHK(g, e) check_val(g, e)

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait; sel picks the reset request, else the interval request
    task automatic wait_for(input bit sel, input int limit);
        int n;
        n = 0;
        while ((sel ? wdt_reset_req : interval_irq) !== 1'b1 && n < limit) begin
            @(negedge clk);
            n++;
        end
        if ((sel ? wdt_reset_req : interval_irq) !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        pats = '{8'hC7, 8'h97, 8'h87};
        left = '{8'h77, 8'h5F, 8'h57};
        reset_n = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        miscompares = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;

        // Reset values and the unmapped place
        rd_chk(WIT_ADDR_CSR_ONE, 8'hF5);
        rd_chk(WIT_ADDR_CSR_TWO, 8'h57);
        rd_chk(WIT_ADDR_COUNTER, 8'h00);
        rd_chk(WIT_ADDR_CLK_MODE, 8'hFF);
        wr_reg(3'h7, 8'hA5);
        rd_chk(3'h7, 8'h00);

        // Run bit refused without prior enable, or with guard set
        wr_reg(WIT_ADDR_CSR_ONE, 8'h0A);
        rd_chk(WIT_ADDR_CSR_ONE, 8'hFD);
        wr_reg(WIT_ADDR_CSR_ONE, 8'h0E);
        rd_chk(WIT_ADDR_CSR_ONE, 8'hFD);

        // Interval mode; guarded write leaves mode alone
        wr_reg(WIT_ADDR_CSR_TWO, 8'h78);
        rd_chk(WIT_ADDR_CSR_TWO, 8'h57);
        wr_reg(WIT_ADDR_CSR_TWO, 8'h28);
        rd_chk(WIT_ADDR_CSR_TWO, 8'h7F);
        wr_reg(WIT_ADDR_CLK_MODE, 8'h08);
        rd_chk(WIT_ADDR_CLK_MODE, 8'hF8);
        wr_reg(WIT_ADDR_COUNTER, 8'hFE);
        rd_chk(WIT_ADDR_COUNTER, 8'hFE);
        wr_reg(WIT_ADDR_IRQ_MASK, 8'h01);
        wr_reg(WIT_ADDR_CLK_STOP, 8'h01);
        wr_reg(WIT_ADDR_CSR_ONE, 8'h0A);
        rd_chk(WIT_ADDR_CSR_ONE, 8'hFF);
        `CHK(8'(module_standby), 8'h00);

        // Two pulses of 64 clocks from 0xFE reach the overflow
        idle(90);
        `CHK(8'(interval_irq), 8'h00);
        wait_for(1'b0, 200);
        `CHK(8'(wdt_reset_req), 8'h00);
        idle(2);
        `CHK(8'(irq), 8'h01);
        rd_chk(WIT_ADDR_CSR_TWO, 8'hFF);
        rd_chk(WIT_ADDR_COUNTER, 8'h00);
        rd_chk(WIT_ADDR_IRQ_STATUS, 8'h03);

        // Mask, then clear the sticky status
        wr_reg(WIT_ADDR_IRQ_MASK, 8'h00);
        idle(2);
        `CHK(8'(irq), 8'h00);
        wr_reg(WIT_ADDR_IRQ_MASK, 8'h01);
        wr_reg(WIT_ADDR_IRQ_STATUS, 8'h03);
        idle(2);
        `CHK(8'(irq), 8'h00);
        rd_chk(WIT_ADDR_IRQ_STATUS, 8'h00);

        // Flag clear needs a read of 1 since the last write
        wr_reg(WIT_ADDR_CSR_TWO, 8'hD7);
        wr_reg(WIT_ADDR_CSR_TWO, 8'h57);
        rd_chk(WIT_ADDR_CSR_TWO, 8'hFF);
        `CHK(8'(interval_irq), 8'h01);
        wr_reg(WIT_ADDR_CSR_TWO, 8'h57);
        idle(2);
        `CHK(8'(interval_irq), 8'h00);
        rd_chk(WIT_ADDR_CSR_TWO, 8'h7F);

        // Stop request waits for the run bit to fall
        wr_reg(WIT_ADDR_CSR_ONE, 8'h08);
        idle(2);
        `CHK(8'(module_standby), 8'h01);
        rd_chk(WIT_ADDR_CSR_ONE, 8'hFD);

        // Clear patterns for mode and enable bits
        for (int i = 0; i < 3; i++) begin
            wr_reg(WIT_ADDR_CSR_TWO, 8'h28);
            wr_reg(WIT_ADDR_CSR_TWO, pats[i]);
            rd_chk(WIT_ADDR_CSR_TWO, left[i]);
        end

        // Watchdog overflow from 0xFF after one pulse
        wr_reg(WIT_ADDR_COUNTER, 8'hFF);
        wr_reg(WIT_ADDR_CSR_ONE, 8'h0A);
        wait_for(1'b1, 300);
        `CHK(8'(interval_irq), 8'h00);
        wr_reg(WIT_ADDR_COUNTER, 8'h55);
        width = 2;
        while (wdt_reset_req === 1'b1 && width < 4000) begin
            @(negedge clk);
            width++;
        end
        // Synchroniser jitter allows a few cycles either way
        `CHK(8'(width >= 2554 && width <= 2566), 8'h01);
        idle(2);
        rd_chk(WIT_ADDR_CSR_ONE, 8'hF5);
        rd_chk(WIT_ADDR_CSR_TWO, 8'h57);
        rd_chk(WIT_ADDR_COUNTER, 8'h00);
        rd_chk(WIT_ADDR_CLK_MODE, 8'hFF);
        rd_chk(WIT_ADDR_CLK_STOP, 8'h00);
        `CHK(8'(module_standby), 8'h00);

        // Interval count on the oscillator: 2048 ticks of 5 clocks per step
        wr_reg(WIT_ADDR_CSR_TWO, 8'h28);
        wr_reg(WIT_ADDR_CLK_MODE, 8'h00);
        wr_reg(WIT_ADDR_COUNTER, 8'hFF);
        wr_reg(WIT_ADDR_CSR_ONE, 8'h08);
        wr_reg(WIT_ADDR_CSR_ONE, 8'h0A);
        rd_chk(WIT_ADDR_CLK_MODE, 8'hF0);
        idle(10200);
        `CHK(8'(interval_irq), 8'h00);
        wait_for(1'b0, 100);
        `CHK(8'(wdt_reset_req), 8'h00);
        rd_chk(WIT_ADDR_COUNTER, 8'h00);
        conclude();
    end
endmodule
